//--- core/rtc_outputs.sv
// Purpose: square wave, fixed 32 kHz, reset supervisor, power-fail gating, century bits
// Assumes: all inputs except the two reset inputs synchronous to clk_sys_i; oscillator emulated by phase accumulator
// Notes: pins are out/oe pairs; a released pin reads high through its pull-up
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`include "rtc_outputs_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module rtc_outputs #(
	parameter int REC_DEF_CYC  = `REC_DEF_NS / `CLK_NS,
	parameter int REC_STOP_CYC = `REC_STOP_NS / `CLK_NS
) (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	// avalon-mm slave
	input  wire logic [7:0]  av_address_i,
	input  wire logic        av_read_i,
	input  wire logic        av_write_i,
	input  wire logic [31:0] av_writedata_i,
	input  wire logic [3:0]  av_byteenable_i,
	output logic      [31:0] av_readdata_o,
	output logic             av_waitrequest_o,
	// supervisor inputs
	input  wire logic        supply_fail_i,
	input  wire logic        battery_backup_i,
	input  wire logic        reset_input_a_i,
	input  wire logic        reset_input_b_i,
	input  wire logic        power_fail_input_a_i,
	input  wire logic        power_fail_input_b_i,
	// calendar
	input  wire logic        year_tick_i,
	output logic             leap_year_o,
	// pins
	output logic             square_wave_pin_o,
	output logic             square_wave_pin_oe_o,
	output logic             fixed_32k_pin_o,
	output logic             fixed_32k_pin_oe_o,
	output logic             reset_pin_o,
	output logic             reset_pin_oe_o,
	output logic             power_fail_output_a_o,
	output logic             power_fail_output_a_oe_o,
	output logic             power_fail_output_b_o,
	output logic             power_fail_output_b_oe_o
);
	rtc_outputs_pkg::state_t s;
	rtc_outputs_pkg::state_t n;

	logic [1:0]  rin;
	logic [1:0]  below;
	logic [1:0]  act;
	logic [1:0]  valid;
	logic        hold_req;
	logic [24:0] acc_sum;
	logic [5:0]  idx;
	logic        wr_en;
	logic [7:0]  wd;
	logic [7:0]  rd;
	logic        sq_lvl;
	logic        sq_on;
	logic [23:0] rec_len;

	assign rin   = {reset_input_b_i, reset_input_a_i};
	assign below = {power_fail_input_b_i, power_fail_input_a_i};
	assign idx   = av_address_i[7:2];
	assign wd    = av_writedata_i[7:0];

	// open drain only pulls low; push-pull drives the level
	function automatic rtc_outputs_pkg::pin_t drive(input logic lvl, input logic od);
		rtc_outputs_pkg::pin_t p;
		p.out = od ? 1'b0 : lvl;
		p.oe  = od ? ~lvl : 1'b1;
		return p;
	endfunction : drive

	function automatic logic pin_lvl(input rtc_outputs_pkg::pin_t p);
		return p.oe ? p.out : 1'b1;
	endfunction : pin_lvl

	// bcd year: tens parity decides which units are multiples of four
	function automatic logic is_leap(input logic [7:0] y, input logic [1:0] c);
		logic d4;
		d4 = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		return d4 && (y != 8'h00 || c == 2'h0);
	endfunction : is_leap

	always_comb begin
		n       = s;
		act     = '0;
		valid   = '0;
		rd      = 8'h00;
		acc_sum = {1'b0, s.osc_acc} + {1'b0, `OSC_INC};
		wr_en   = av_write_i && !s.waitrq && av_byteenable_i[0];

		// read mux; unmapped reads return zero
		case (idx)
			`IDX_RECOV:   rd = {s.recovery_select, 7'h00};
			`IDX_YEAR:    rd = s.year;
			`IDX_CENTURY: rd = {s.century, 6'h00};
			`IDX_SQCTL:   rd = {s.alarm_flag_enable, s.square_wave_enable, s.alarm_backup_enable, 5'h00};
			`IDX_RATE:    rd = {4'h0, s.square_rate_select};
			`IDX_CTRL:    rd = s.ctrl;
			`IDX_WDOG:    rd = s.wdog;
			`IDX_STAT:    rd = {4'h0, ~pin_lvl(s.pf[1]), ~pin_lvl(s.pf[0]), s.cause_supply,
				s.rec != rtc_outputs_pkg::REC_IDLE};
			default:      rd = 8'h00;
		endcase

		// one wait cycle, then answer; write lands on the edge seeing waitrequest low
		n.waitrq = 1'b1;
		if ((av_read_i || av_write_i) && s.waitrq) begin
			n.waitrq = 1'b0;
			n.rdata  = {24'h000000, rd};
		end

		// oscillator emulation: div counts at 65.536 kHz
		if (!s.ctrl.oscillator_stop) begin
			n.osc_acc = acc_sum[23:0];
			if (acc_sum[24])
				n.div = s.div + 16'h0001;
		end

		// calendar year and century
		if (year_tick_i) begin
			if (s.year == `YEAR_LAST) begin
				n.year    = 8'h00;
				n.century = s.century + 2'h1;
			end else if (s.year[3:0] == 4'h9) begin
				n.year = {s.year[7:4] + 4'h1, 4'h0};
			end else begin
				n.year = s.year + 8'h01;
			end
		end
		n.leap = is_leap(s.year, s.century);

		// register writes win over the year tick
		if (wr_en) begin
			case (idx)
				`IDX_RECOV:   n.recovery_select = wd[7];
				`IDX_YEAR:    n.year = wd;
				`IDX_CENTURY: n.century = wd[7:6];
				`IDX_SQCTL: begin
					n.alarm_flag_enable   = wd[7];
					n.square_wave_enable  = wd[6];
					n.alarm_backup_enable = wd[5];
				end
				`IDX_RATE:    n.square_rate_select = wd[3:0];
				`IDX_CTRL:    n.ctrl = wd;
				`IDX_WDOG:    n.wdog = wd;
				default: begin
				end
			endcase
		end

		// reset inputs: two-flop sync, edge, width filter
		for (int i = 0; i < 2; i++) begin
			n.rin_sync[i] = {s.rin_sync[i][0], rin[i]};
			act[i] = (i == 0) ? ~s.rin_sync[i][1] : s.rin_sync[i][1];
			n.rin_prev[i] = act[i];
			valid[i] = s.armed[i] && act[i] && (s.wid[i] >= 3'(`RIN_MIN_CYC));
			if (!act[i]) begin
				n.armed[i] = 1'b0;
				n.wid[i]   = 3'h0;
			end else if (!s.rin_prev[i]) begin
				n.armed[i] = 1'b1;
				n.wid[i]   = 3'h1;
			end else if (s.armed[i] && s.wid[i] < 3'h7) begin
				n.wid[i] = s.wid[i] + 3'h1;
			end
		end
		hold_req = supply_fail_i || (|valid);

		// recovery length; fast setting ignores the stop bit
		if (s.recovery_select)
			rec_len = 24'(`REC_FAST_CYC);
		else if (s.ctrl.oscillator_stop)
			rec_len = 24'(REC_STOP_CYC);
		else
			rec_len = 24'(REC_DEF_CYC);

		if (supply_fail_i)
			n.cause_supply = 1'b1;
		case (s.rec)
			rtc_outputs_pkg::REC_IDLE: begin
				if (hold_req)
					n.rec = rtc_outputs_pkg::REC_HOLD;
			end
			rtc_outputs_pkg::REC_HOLD: begin
				if (!hold_req) begin
					n.rec     = rtc_outputs_pkg::REC_WAIT;
					n.rec_cnt = rec_len - 24'h000001;
				end
			end
			rtc_outputs_pkg::REC_WAIT: begin
				if (hold_req) begin
					n.rec = rtc_outputs_pkg::REC_HOLD;
				end else if (s.rec_cnt == 24'h000000) begin
					n.rec          = rtc_outputs_pkg::REC_IDLE;
					n.cause_supply = 1'b0;
				end else begin
					n.rec_cnt = s.rec_cnt - 24'h000001;
				end
			end
			default: n.rec = rtc_outputs_pkg::REC_IDLE;
		endcase

		// device reset clears only the irq, test, alarm and square enables and the watchdog
		if (s.rec == rtc_outputs_pkg::REC_HOLD) begin
			n.ctrl.osc_fail_irq_enable = 1'b0;
			n.ctrl.frequency_test      = 1'b0;
			n.ctrl.tamper_irq_enable_a = 1'b0;
			n.ctrl.tamper_irq_enable_b = 1'b0;
			n.alarm_flag_enable        = 1'b0;
			n.alarm_backup_enable      = 1'b0;
			n.square_wave_enable       = 1'b0;
			n.wdog                     = 8'h00;
		end

		// square wave pin, with 512 Hz test tone when disabled
		sq_on  = 1'b0;
		sq_lvl = 1'b1;
		if (!s.ctrl.oscillator_stop) begin
			if (s.square_wave_enable && s.square_rate_select != 4'h0) begin
				sq_on  = 1'b1;
				sq_lvl = (s.square_rate_select == 4'h1) ? s.div[0] : s.div[s.square_rate_select];
			end else if (s.ctrl.frequency_test && !s.square_wave_enable) begin
				sq_on  = 1'b1;
				sq_lvl = s.div[`FT_CODE];
			end
		end
		n.sq = drive(sq_on ? sq_lvl : 1'b1, s.ctrl.square_drive_type);

		// fixed 32 kHz pin is open drain
		n.fixed_32k_pin = drive((s.ctrl.fixed_32k_enable && !s.ctrl.oscillator_stop) ? s.div[0] : 1'b1, 1'b1);
		n.rst  = drive(s.rec == rtc_outputs_pkg::REC_IDLE, 1'b1);

		for (int i = 0; i < 2; i++) begin
			if (battery_backup_i)
				n.pf[i] = drive(1'b0, s.ctrl.power_fail_drive_type);
			else if (s.rec != rtc_outputs_pkg::REC_IDLE && s.cause_supply)
				n.pf[i] = drive(1'b1, s.ctrl.power_fail_drive_type);
			else
				n.pf[i] = drive(~below[i], s.ctrl.power_fail_drive_type);
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s          <= '0;
			s.ctrl     <= `CTRL_RESET;
			s.waitrq   <= 1'b1;
			// sync flops of a start high and those of b start low, each at its idle level, else a sees a false falling edge
			s.rin_sync <= 4'h3;
			s.sq       <= 2'h0;
			s.fixed_32k_pin     <= 2'h0;
			s.rst      <= 2'h1;
			s.pf       <= 4'h0;
		end else begin
			s <= n;
		end
	end

	assign av_readdata_o            = s.rdata;
	assign av_waitrequest_o         = s.waitrq;
	assign leap_year_o              = s.leap;
	assign square_wave_pin_o        = s.sq.out;
	assign square_wave_pin_oe_o     = s.sq.oe;
	assign fixed_32k_pin_o          = s.fixed_32k_pin.out;
	assign fixed_32k_pin_oe_o       = s.fixed_32k_pin.oe;
	assign reset_pin_o              = s.rst.out;
	assign reset_pin_oe_o           = s.rst.oe;
	assign power_fail_output_a_o    = s.pf[0].out;
	assign power_fail_output_a_oe_o = s.pf[0].oe;
	assign power_fail_output_b_o    = s.pf[1].out;
	assign power_fail_output_b_oe_o = s.pf[1].oe;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	sequence hold_seen;
		s.rec == rtc_outputs_pkg::REC_HOLD;
	endsequence
	sequence rst_low;
		reset_pin_oe_o && !reset_pin_o;
	endsequence

	a_sq_off_idle: assert property (!s.square_wave_enable && !s.ctrl.frequency_test |=>
		pin_lvl(s.sq)) else $error("square pin not idle while disabled");
	a_sq_od_low: assert property (s.ctrl.square_drive_type |=> !(s.sq.oe && s.sq.out))
		else $error("open-drain square pin drove high");
	a_fixed_32k_pin_stop: assert property (s.ctrl.oscillator_stop || !s.ctrl.fixed_32k_enable |=>
		!s.fixed_32k_pin.oe) else $error("fixed 32k pin active while off");
	a_rst_hold_low: assert property (hold_seen |=> rst_low)
		else $error("reset pin not low during hold");
	a_clear_bits: assert property (hold_seen |=> !s.square_wave_enable && s.wdog == 8'h00
		&& !s.alarm_flag_enable) else $error("control bits not cleared by reset");
	a_rin_edge: assert property (s.rin_sync[0][1] ##1 !s.rin_sync[0][1] [*2] ##1 1'b1
		|-> s.armed[0]) else $error("falling edge of input a not armed");
	a_rec_release: assert property (s.rec == rtc_outputs_pkg::REC_WAIT && s.rec_cnt == 24'h0
		&& !hold_req |=> s.rec == rtc_outputs_pkg::REC_IDLE ##1 !reset_pin_oe_o)
		else $error("reset not released at end of recovery");
	a_pf_backup: assert property (battery_backup_i |=> !pin_lvl(s.pf[0]) && !pin_lvl(s.pf[1]))
		else $error("power-fail output high in backup");
	a_pf_od_low: assert property (s.ctrl.power_fail_drive_type |=> !(s.pf[0].oe && s.pf[0].out)
		&& !(s.pf[1].oe && s.pf[1].out)) else $error("open-drain power-fail drove high");
	a_century_wrap: assert property (year_tick_i && s.year == `YEAR_LAST && !wr_en |=>
		s.century == $past(s.century) + 2'h1) else $error("century did not advance");
	a_leap_flag: assert property (year_tick_i == 1'b0 && !wr_en && s.year == 8'h00
		&& s.century != 2'h0 |=> ##1 !leap_year_o) else $error("century year wrongly leap");
endmodule : rtc_outputs
`default_nettype wire

//--- inc/rtc_outputs_defines.svh
// Purpose: constants of the rtc output, reset and century block
// Assumes: 10 MHz system clock, byte addresses on the register bus
// Notes: register index times four gives the byte address
`ifndef RTC_OUTPUTS_DEFINES_SVH
`define RTC_OUTPUTS_DEFINES_SVH
`define IDX_RECOV      6'h04
`define IDX_YEAR       6'h06
`define IDX_CENTURY    6'h07
`define IDX_SQCTL      6'h0a
`define IDX_RATE       6'h13
`define IDX_CTRL       6'h14
`define IDX_WDOG       6'h15
`define IDX_STAT       6'h16
`define CTRL_RESET     8'h04
`define OSC_INC        24'h01ad7f
`define FT_CODE        4'h6
`define YEAR_LAST      8'h99
`define CLK_NS         100
`define REC_DEF_NS     96000000
`define REC_STOP_NS    40000000
`define REC_FAST_NS    50000
`define RIN_MIN_NS     100
`define REC_FAST_CYC   ((`REC_FAST_NS + `CLK_NS - 1) / `CLK_NS)
`define RIN_MIN_CYC    ((`RIN_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`endif

//--- inc/rtc_outputs_pkg.sv
// Purpose: types of the rtc output, reset and century block
// Assumes: nothing beyond the defines header
// Notes: whole block state is one packed struct
package rtc_outputs_pkg;
	typedef enum logic [1:0] {REC_IDLE = 2'b00, REC_HOLD = 2'b01, REC_WAIT = 2'b11} rec_state_t;
	typedef struct packed {
		logic tamper_irq_enable_b;
		logic tamper_irq_enable_a;
		logic osc_fail_irq_enable;
		logic frequency_test;
		logic oscillator_stop;
		logic fixed_32k_enable;
		logic power_fail_drive_type;
		logic square_drive_type;
	} ctrl_t;
	typedef struct packed {
		logic out;
		logic oe;
	} pin_t;
	typedef struct packed {
		rec_state_t       rec;
		logic [23:0]      rec_cnt;
		logic             cause_supply;
		logic [1:0][1:0]  rin_sync;
		logic [1:0]       rin_prev;
		logic [1:0]       armed;
		logic [1:0][2:0]  wid;
		logic [23:0]      osc_acc;
		logic [15:0]      div;
		ctrl_t            ctrl;
		logic             recovery_select;
		logic             alarm_flag_enable;
		logic             square_wave_enable;
		logic             alarm_backup_enable;
		logic [3:0]       square_rate_select;
		logic [7:0]       year;
		logic [1:0]       century;
		logic [7:0]       wdog;
		logic             waitrq;
		logic [31:0]      rdata;
		pin_t             sq;
		pin_t             fixed_32k_pin;
		pin_t             rst;
		pin_t [1:0]       pf;
		logic             leap;
	} state_t;
endpackage : rtc_outputs_pkg

//--- dv/rtc_host_model.sv
// Purpose: host side of the reset and power-fail lines
// Assumes: every host line has a pull-up, as open drain drive needs
// Notes: levels are what the host processor really sees
`timescale 1ns/100ps
`default_nettype none
module rtc_host_model (
	// pins from the block
	input  wire logic rst_out_i,
	input  wire logic rst_oe_i,
	input  wire logic pfa_out_i,
	input  wire logic pfa_oe_i,
	input  wire logic pfb_out_i,
	input  wire logic pfb_oe_i,
	// levels seen by the host
	output logic      rst_lvl_o,
	output logic      pfa_lvl_o,
	output logic      pfb_lvl_o
);
	// released line floats up, never keeps the last driven value
	assign rst_lvl_o = rst_oe_i ? rst_out_i : 1'b1;
	assign pfa_lvl_o = pfa_oe_i ? pfa_out_i : 1'b1;
	assign pfb_lvl_o = pfb_oe_i ? pfb_out_i : 1'b1;
endmodule : rtc_host_model
`default_nettype wire

//--- dv/rtc_outputs_tb.sv
// Purpose: self-checking bench of the rtc output, reset and century block
// Assumes: recovery counts shortened to 50 and 30 cycles
// Notes: rates are checked by counting pin toggles over fixed windows
`timescale 1ns/100ps
`default_nettype none
module rtc_outputs_tb;
	localparam int REC = 50;
	int          err_count = 0;
	int          n_compared = 0;
	logic        clk_sys_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  av_address_i = 8'h00;
	logic        av_read_i = 1'b0;
	logic        av_write_i = 1'b0;
	logic [31:0] av_writedata_i = 32'h0;
	logic [3:0]  av_byteenable_i = 4'h1;
	logic        supply_fail_i = 1'b0;
	logic        battery_backup_i = 1'b0;
	logic        reset_input_a_i = 1'b1;
	logic        reset_input_b_i = 1'b0;
	logic        power_fail_input_a_i = 1'b0;
	logic        power_fail_input_b_i = 1'b0;
	logic        year_tick_i = 1'b0;
	logic [31:0] av_readdata_o;
	logic        av_waitrequest_o, leap_year_o, square_wave_pin_o, square_wave_pin_oe_o;
	logic        fixed_32k_pin_o, fixed_32k_pin_oe_o, reset_pin_o, reset_pin_oe_o;
	logic        power_fail_output_a_o, power_fail_output_a_oe_o, power_fail_output_b_o, power_fail_output_b_oe_o;
	logic        rst_lvl, pfa_lvl, pfb_lvl;
	wire logic   sq_lvl = square_wave_pin_oe_o ? square_wave_pin_o : 1'b1;
	wire logic   fixed_32k_pin_lvl = fixed_32k_pin_oe_o ? fixed_32k_pin_o : 1'b1;

	rtc_outputs #(.REC_DEF_CYC(REC), .REC_STOP_CYC(30)) i_dut (.clk_sys_i, .rst_i, .av_address_i, .av_read_i,
		.av_write_i, .av_writedata_i, .av_byteenable_i, .av_readdata_o, .av_waitrequest_o, .supply_fail_i,
		.battery_backup_i, .reset_input_a_i, .reset_input_b_i, .power_fail_input_a_i, .power_fail_input_b_i,
		.year_tick_i, .leap_year_o, .square_wave_pin_o, .square_wave_pin_oe_o, .fixed_32k_pin_o,
		.fixed_32k_pin_oe_o, .reset_pin_o, .reset_pin_oe_o, .power_fail_output_a_o, .power_fail_output_a_oe_o,
		.power_fail_output_b_o, .power_fail_output_b_oe_o);
	rtc_host_model i_host (.rst_out_i(reset_pin_o), .rst_oe_i(reset_pin_oe_o), .pfa_out_i(power_fail_output_a_o),
		.pfa_oe_i(power_fail_output_a_oe_o), .pfb_out_i(power_fail_output_b_o), .pfb_oe_i(power_fail_output_b_oe_o),
		.rst_lvl_o(rst_lvl), .pfa_lvl_o(pfa_lvl), .pfb_lvl_o(pfb_lvl));

	initial begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	task automatic report_and_stop;
		$display("compared %0d, errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic hang;
		err_count++;
		$display("[ERR] wait limit expected answer seen none");
		report_and_stop();
	endtask : hang

	task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp8

	task automatic cmpn(input string what, input int lo, input int hi, input int got);
		n_compared++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : cmpn

	// request held until waitrequest is sampled low
	task automatic bus(input logic wr_en, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] rdv);
		int n;
		@(posedge clk_sys_i);
		av_address_i <= {idx, 2'b00};
		av_writedata_i <= {24'h0, wd};
		av_write_i <= wr_en;
		av_read_i <= ~wr_en;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (av_waitrequest_o !== 1'b0 && n < 20);
		if (n >= 20) hang();
		rdv = av_readdata_o[7:0];
		av_write_i <= 1'b0;
		av_read_i <= 1'b0;
	endtask : bus

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [7:0] x;
		bus(1'b1, idx, d, x);
	endtask : wr

	task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
		logic [7:0] x;
		bus(1'b0, idx, 8'h00, x);
		cmp8($sformatf("register %h", idx), exp, x);
	endtask : rd

	// hi counts cycles where the square pin actively drives high
	task automatic toggles(input logic sel, input int cyc, output int t, output int hi);
		logic prev;
		// let a just-written control value reach the pin before counting
		repeat (2) @(posedge clk_sys_i);
		prev = sel ? fixed_32k_pin_lvl : sq_lvl;
		t = 0;
		hi = 0;
		repeat (cyc) begin
			@(posedge clk_sys_i);
			if ((sel ? fixed_32k_pin_lvl : sq_lvl) !== prev) t++;
			prev = sel ? fixed_32k_pin_lvl : sq_lvl;
			if (square_wave_pin_oe_o === 1'b1 && square_wave_pin_o === 1'b1) hi++;
		end
	endtask : toggles

	task automatic rst_wait(input logic lvl, input int lim, output int n);
		n = 0;
		while (rst_lvl !== lvl) begin
			@(posedge clk_sys_i);
			n++;
			if (n > lim) hang();
		end
	endtask : rst_wait

	initial begin
		int t, h, n;
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rd(6'h14, 8'h04);
		rd(6'h0a, 8'h00);
		rd(6'h15, 8'h00);
		rd(6'h30, 8'h00);
		toggles(1'b1, 3052, t, h);
		cmpn("fixed 32k toggles", 18, 22, t);
		wr(6'h14, 8'h0c);
		toggles(1'b1, 1000, t, h);
		cmpn("stopped 32k toggles", 0, 0, t);
		wr(6'h14, 8'h00);
		toggles(1'b1, 1000, t, h);
		cmpn("disabled 32k toggles", 0, 0, t);
		wr(6'h14, 8'h04);
		wr(6'h0a, 8'h40);
		for (int k = 1; k < 5; k++) begin
			wr(6'h13, 8'(k));
			toggles(1'b0, 12208, t, h);
			n = (k == 1) ? 80 : (40 >> (k - 1));
			cmpn("square toggles", n - 2, n + 2, t);
			cmpn("push-pull high drive", 1, 12208, h);
		end
		wr(6'h13, 8'h00);
		toggles(1'b0, 500, t, h);
		cmpn("code zero toggles", 0, 0, t);
		cmp8("idle square level", 8'h01, {7'h0, sq_lvl});
		wr(6'h13, 8'h01);
		wr(6'h0a, 8'h00);
		toggles(1'b0, 1000, t, h);
		cmpn("disabled square toggles", 0, 0, t);
		wr(6'h14, 8'h05);
		wr(6'h0a, 8'h40);
		toggles(1'b0, 3052, t, h);
		cmpn("open drain toggles", 18, 22, t);
		cmpn("open drain high drive", 0, 0, h);
		reset_input_a_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		rst_wait(1'b0, 10, n);
		reset_input_a_i <= 1'b1;
		rst_wait(1'b1, 2000, n);
		cmpn("recovery after input a", REC, REC + 10, n);
		rd(6'h0a, 8'h00);
		rd(6'h13, 8'h01);
		wr(6'h0a, 8'h40);
		reset_input_b_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		reset_input_b_i <= 1'b0;
		rst_wait(1'b0, 10, n);
		rst_wait(1'b1, 2000, n);
		cmpn("recovery after input b", REC, REC + 10, n);
		rd(6'h0a, 8'h00);
		power_fail_input_a_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		cmp8("power fail a low", 8'h01, {6'h0, pfa_lvl, pfb_lvl});
		power_fail_input_a_i <= 1'b0;
		power_fail_input_b_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		cmp8("power fail b low", 8'h02, {6'h0, pfa_lvl, pfb_lvl});
		supply_fail_i <= 1'b1;
		battery_backup_i <= 1'b1;
		power_fail_input_b_i <= 1'b0;
		repeat (5) @(posedge clk_sys_i);
		cmp8("backup power fail", 8'h00, {6'h0, pfa_lvl, pfb_lvl});
		cmp8("supply fail reset", 8'h00, {7'h0, rst_lvl});
		supply_fail_i <= 1'b0;
		battery_backup_i <= 1'b0;
		power_fail_input_a_i <= 1'b1;
		power_fail_input_b_i <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		cmp8("recovery power fail", 8'h03, {6'h0, pfa_lvl, pfb_lvl});
		rst_wait(1'b1, 2000, n);
		cmpn("supply recovery", REC - 5, REC + 10, n);
		repeat (5) @(posedge clk_sys_i);
		cmp8("power fail follows", 8'h00, {6'h0, pfa_lvl, pfb_lvl});
		wr(6'h14, 8'h06);
		power_fail_input_a_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		cmp8("open drain enables", 8'h01, {6'h0, power_fail_output_a_oe_o, power_fail_output_b_oe_o});
		cmp8("open drain levels", 8'h02, {6'h0, pfa_lvl, pfb_lvl});
		wr(6'h07, 8'h00);
		wr(6'h06, 8'h99);
		@(posedge clk_sys_i);
		year_tick_i <= 1'b1;
		@(posedge clk_sys_i);
		year_tick_i <= 1'b0;
		rd(6'h06, 8'h00);
		rd(6'h07, 8'h40);
		for (int c = 0; c < 4; c++) begin
			wr(6'h07, 8'(c << 6));
			repeat (3) @(posedge clk_sys_i);
			cmp8("century year leap", {7'h0, c == 0}, {7'h0, leap_year_o});
		end
		wr(6'h06, 8'h96);
		repeat (3) @(posedge clk_sys_i);
		cmp8("year 96 leap", 8'h01, {7'h0, leap_year_o});
		wr(6'h06, 8'h97);
		repeat (3) @(posedge clk_sys_i);
		cmp8("year 97 leap", 8'h00, {7'h0, leap_year_o});
		report_and_stop();
	end
endmodule : rtc_outputs_tb
`default_nettype wire
